// ---- verilog/svrm_pkg.sv ----
// Purpose: shared constants and types for the supply-voltage reset monitor
// Assumes: clk at 100 MHz, times held in ns
// Notes:   all timing counts derive from the ns figures below
package svrm_pkg;

    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS     = 10;
    // detector reset processing, longest figure
    localparam int LVD_PROC_NS       = 70100;
    localparam int LVD_PROC_CYC      = LVD_PROC_NS / CLK_PERIOD_NS;
    // first external reset release after power-on
    localparam int EXT1_ON_NS        = 832000;
    localparam int EXT1_OFF_NS       = 519000;
    // later external reset releases
    localparam int EXTN_ON_NS        = 675000;
    localparam int EXTN_OFF_NS       = 362000;
    localparam int EXT1_ON_CYC       = EXT1_ON_NS / CLK_PERIOD_NS;
    localparam int EXT1_OFF_CYC      = EXT1_OFF_NS / CLK_PERIOD_NS;
    localparam int EXTN_ON_CYC       = EXTN_ON_NS / CLK_PERIOD_NS;
    localparam int EXTN_OFF_CYC      = EXTN_OFF_NS / CLK_PERIOD_NS;
    // detection level settling wait after interrupt or level change
    localparam int SETTLE_NS         = 10000;
    localparam int SETTLE_CYC        = SETTLE_NS / CLK_PERIOD_NS;
    localparam int CNT_W             = 17;

    // ----------------------------------------------------------------
    // option field codes
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_OFF     = 2'h0;
    localparam logic [1:0] MODE_INT     = 2'h1;
    localparam logic [1:0] MODE_INT_RST = 2'h2;
    localparam logic [1:0] MODE_RST     = 2'h3;

    // ----------------------------------------------------------------
    // register layouts and reset values
    // ----------------------------------------------------------------
    localparam int CTRL_FLAG_BIT     = 0;
    localparam int CTRL_MASK_BIT     = 1;
    localparam int CTRL_REN_BIT      = 7;
    localparam int LVL_THR_BIT       = 0;
    localparam int LVL_MODE_BIT      = 7;
    localparam int CAUSE_LVD_BIT     = 0;
    localparam logic [7:0] LVL_RST_INT_RST = 8'h00;
    localparam logic [7:0] LVL_RST_RST     = 8'h81;
    localparam logic [7:0] LVL_RST_INT     = 8'h01;

    typedef enum {PS_HOLD, PS_PROC, PS_RUN} svrm_proc_e;

    // option byte fields caught at reset
    typedef struct packed {
        logic [1:0] level;
        logic [1:0] mode;
    } svrm_opt_s;

    // comparator results, 1 means supply below that threshold
    typedef struct packed {
        logic below_high;
        logic below_low;
    } svrm_cmp_s;

    function automatic logic [7:0] svrm_lvl_reset(input logic [1:0] mode);
        logic [7:0] v;
        v = LVL_RST_INT_RST;
        if (mode == MODE_RST) begin
            v = LVL_RST_RST;
        end else if (mode == MODE_INT) begin
            v = LVL_RST_INT;
        end
        return v;
    endfunction

endpackage

// ---- verilog/svrm_sync.sv ----
// Purpose: two-stage synchroniser for asynchronous comparator levels
// Assumes: inputs are slow levels, not pulses
// Notes:   first stage feeds only the second stage
module svrm_sync #(
    parameter int W = 2
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb begin
        next_meta = d;
        next_q    = meta;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= next_meta;
            q    <= next_q;
        end
    end
endmodule

// ---- verilog/svrm_timer.sv ----
// Purpose: loadable down counter, busy until it reaches zero
// Assumes: load wins over counting
// Notes:   load_val of zero leaves busy low
module svrm_timer #(
    parameter int W = 17
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output logic              busy
);
    logic [W-1:0] count;
    logic [W-1:0] next_count;

    always_comb begin
        next_count = count;
        if (load) begin
            next_count = load_val;
        end else if (count != '0) begin
            next_count = count - W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign busy = (count != '0);
endmodule

// ---- verilog/svrm_monitor.sv ----
// Purpose: control logic of the supply detector beside power-on reset
// Assumes: comparator inputs asynchronous, all other inputs synchronous
// Notes:   rst is the power-on reset; ext_reset_n is the reset pin
module svrm_monitor
    import svrm_pkg::*;
#(
    parameter int LVD_PROC    = LVD_PROC_CYC,
    parameter int EXT1_ON     = EXT1_ON_CYC,
    parameter int EXT1_OFF    = EXT1_OFF_CYC,
    parameter int EXTN_ON     = EXTN_ON_CYC,
    parameter int EXTN_OFF    = EXTN_OFF_CYC,
    parameter int SETTLE      = SETTLE_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ext_reset_n,
    input  wire svrm_opt_s  opt_byte,
    input  wire svrm_cmp_s  cmp_async,
    input  wire logic       hoco_accurate,
    input  wire logic       ctrl_wr,
    input  wire logic [7:0] ctrl_wdata,
    input  wire logic       lvl_wr,
    input  wire logic [7:0] lvl_wdata,
    input  wire logic       cause_clear,
    input  wire logic       clk_switch_req,
    output svrm_opt_s       threshold_cfg,
    output logic            internal_reset,
    output logic            low_supply_irq,
    output logic            cpu_on_chip_osc,
    output logic [7:0]      detector_control_reg,
    output logic [7:0]      detector_level_reg,
    output logic [7:0]      reset_cause_reg
);

    // ----------------------------------------------------------------
    // comparator synchronisation
    // ----------------------------------------------------------------
    svrm_cmp_s cmp;
    logic [1:0] cmp_bits;

    svrm_sync #(.W(2)) u_sync (
        .clk (clk),
        .rst (rst),
        .d   (cmp_async),
        .q   (cmp_bits)
    );
    assign cmp = svrm_cmp_s'(cmp_bits);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    svrm_proc_e state;
    svrm_proc_e next_state;
    svrm_opt_s  next_opt;
    svrm_cmp_s  cmp_prev;
    logic       lvd_hold;
    logic       next_lvd_hold;
    logic       flag;
    logic       next_flag;
    logic       mask;
    logic       next_mask;
    logic       ren;
    logic       next_ren;
    logic       reset_mode_select_bit;
    logic       next_reset_mode_select_bit;
    logic       threshold_select_bit;
    logic       next_threshold_select_bit;
    logic       cause;
    logic       next_cause;
    logic       irq;
    logic       next_irq;
    logic       from_ext;
    logic       next_from_ext;
    logic       first_ext;
    logic       next_first_ext;
    logic       int_rst;
    logic       next_int_rst;
    logic       osc_sel;
    logic       next_osc_sel;

    logic       ext_low;
    logic       det_on;
    logic       mode_ir;
    logic       below_sel;
    logic       lvd_req;
    logic       any_src;
    logic       irq_event;
    logic       lvl_write_ok;
    logic [7:0] lvl_default;
    logic       settle_load;
    logic       settle_busy;
    logic       proc_load;
    logic       proc_busy;
    logic [CNT_W-1:0] proc_len;

    // ----------------------------------------------------------------
    // timers
    // ----------------------------------------------------------------
    svrm_timer #(.W(CNT_W)) u_proc (
        .clk      (clk),
        .rst      (rst),
        .load     (proc_load),
        .load_val (proc_len),
        .busy     (proc_busy)
    );

    svrm_timer #(.W(CNT_W)) u_settle (
        .clk      (clk),
        .rst      (rst),
        .load     (settle_load),
        .load_val (CNT_W'(SETTLE)),
        .busy     (settle_busy)
    );

    // ----------------------------------------------------------------
    // detector decisions
    // ----------------------------------------------------------------
    always_comb begin
        ext_low   = !ext_reset_n;
        det_on    = (threshold_cfg.mode != MODE_OFF);
        mode_ir   = (threshold_cfg.mode == MODE_INT_RST);
        // only mode 1,0 has two levels; others use the single one
        below_sel = (mode_ir && !threshold_select_bit) ? cmp.below_high
                                        : cmp.below_low;
        lvd_req   = det_on && lvd_hold;
        any_src   = ext_low || lvd_req;
        irq_event = 1'b0;
        if (mode_ir) begin
            irq_event = cmp.below_high && !cmp_prev.below_high
                        && !mask && !lvd_hold && (state == PS_RUN);
        end else if (threshold_cfg.mode == MODE_INT) begin
            irq_event = (cmp.below_low != cmp_prev.below_low)
                        && !lvd_hold && (state == PS_RUN);
        end
        lvl_write_ok = lvl_wr && ren && mode_ir;
        lvl_default  = svrm_lvl_reset(next_opt.mode);
        settle_load  = irq_event
                       || (lvl_write_ok && lvl_wdata[LVL_THR_BIT] != threshold_select_bit);
    end

    // ----------------------------------------------------------------
    // register and flag next values
    // ----------------------------------------------------------------
    always_comb begin
        // option byte is caught only while a pin or power-on reset holds
        next_opt = threshold_cfg;
        if (state == PS_HOLD && from_ext) begin
            next_opt = opt_byte;
        end
        next_flag  = det_on && below_sel;
        next_irq   = irq_event;
        next_ren   = ren;
        next_reset_mode_select_bit = reset_mode_select_bit;
        next_threshold_select_bit = threshold_select_bit;
        if (ctrl_wr && mode_ir) begin
            next_ren = ctrl_wdata[CTRL_REN_BIT];
        end
        if (lvl_write_ok) begin
            next_reset_mode_select_bit = lvl_wdata[LVL_MODE_BIT];
            next_threshold_select_bit = lvl_wdata[LVL_THR_BIT];
        end
        if (irq_event && mode_ir) begin
            next_reset_mode_select_bit = 1'b1;
            next_threshold_select_bit = 1'b1;
        end
        // a detector reset leaves these alone; a pin reset reloads
        if (ext_low) begin
            next_ren   = 1'b0;
            next_reset_mode_select_bit = lvl_default[LVL_MODE_BIT];
            next_threshold_select_bit = lvl_default[LVL_THR_BIT];
        end
        next_mask = mode_ir && (next_ren || settle_busy);

        case (threshold_cfg.mode)
            MODE_INT_RST: begin
                if (lvd_hold) begin
                    next_lvd_hold = cmp.below_high;
                end else begin
                    next_lvd_hold = cmp.below_low && !mask;
                end
            end
            MODE_RST: begin
                next_lvd_hold = cmp.below_low;
            end
            MODE_INT: begin
                next_lvd_hold = lvd_hold && cmp.below_low;
            end
            default: begin
                // kept until the option byte is caught after reset
                next_lvd_hold = lvd_hold;
            end
        endcase
        if (ext_low) begin
            next_lvd_hold = 1'b1;
        end

        // set wins over software clear; the pin clears the cause
        next_cause = cause;
        if (cause_clear || ext_low) begin
            next_cause = 1'b0;
        end
        if (det_on && next_lvd_hold && !lvd_hold && !ext_low) begin
            next_cause = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // reset processing sequence
    // ----------------------------------------------------------------
    always_comb begin
        next_state     = state;
        next_from_ext  = from_ext;
        next_first_ext = first_ext;
        proc_load      = 1'b0;
        if (from_ext) begin
            if (first_ext) begin
                proc_len = det_on ? CNT_W'(EXT1_ON)
                                  : CNT_W'(EXT1_OFF);
            end else begin
                proc_len = det_on ? CNT_W'(EXTN_ON)
                                  : CNT_W'(EXTN_OFF);
            end
        end else begin
            proc_len = CNT_W'(LVD_PROC);
        end
        if (ext_low) begin
            next_from_ext = 1'b1;
        end
        case (state)
            PS_HOLD: begin
                if (!any_src) begin
                    next_state = PS_PROC;
                    proc_load  = 1'b1;
                end
            end
            PS_PROC: begin
                if (any_src) begin
                    next_state = PS_HOLD;
                end else if (!proc_busy && hoco_accurate) begin
                    next_state = PS_RUN;
                    if (from_ext) begin
                        next_first_ext = 1'b0;
                    end
                    next_from_ext = 1'b0;
                end
            end
            default: begin
                if (any_src) begin
                    next_state = PS_HOLD;
                end
            end
        endcase
        next_int_rst = (next_state != PS_RUN);
        // every reset returns the CPU to the on-chip oscillator
        next_osc_sel = osc_sel;
        if (next_int_rst) begin
            next_osc_sel = 1'b1;
        end else if (clk_switch_req) begin
            next_osc_sel = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            state           <= PS_HOLD;
            threshold_cfg   <= '{level: 2'h0, mode: MODE_OFF};
            cmp_prev        <= '0;
            lvd_hold        <= 1'b1;
            flag            <= 1'b0;
            mask            <= 1'b0;
            ren             <= 1'b0;
            reset_mode_select_bit           <= LVL_RST_INT_RST[LVL_MODE_BIT];
            threshold_select_bit           <= LVL_RST_INT_RST[LVL_THR_BIT];
            cause           <= 1'b0;
            irq             <= 1'b0;
            from_ext        <= 1'b1;
            first_ext       <= 1'b1;
            int_rst         <= 1'b1;
            osc_sel         <= 1'b1;
        end else begin
            state           <= next_state;
            threshold_cfg   <= next_opt;
            cmp_prev        <= cmp;
            lvd_hold        <= next_lvd_hold;
            flag            <= next_flag;
            mask            <= next_mask;
            ren             <= next_ren;
            reset_mode_select_bit           <= next_reset_mode_select_bit;
            threshold_select_bit           <= next_threshold_select_bit;
            cause           <= next_cause;
            irq             <= next_irq;
            from_ext        <= next_from_ext;
            first_ext       <= next_first_ext;
            int_rst         <= next_int_rst;
            osc_sel         <= next_osc_sel;
        end
    end

    // ----------------------------------------------------------------
    // outputs, straight from flip-flops
    // ----------------------------------------------------------------
    assign internal_reset       = int_rst;
    assign low_supply_irq       = irq;
    assign cpu_on_chip_osc      = osc_sel;
    assign detector_control_reg = {ren, 5'h00, mask, flag};
    assign detector_level_reg   = {reset_mode_select_bit, 6'h00, threshold_select_bit};
    assign reset_cause_reg      = {7'h00, cause};

endmodule

// ---- test/svrm_monitor_sva.sv ----
// Purpose: port-level relations of the supply monitor
// Assumes: bound onto svrm_monitor from the bench top file
// Notes:   timing figures are checked by the bench, not here
module svrm_monitor_sva
    import svrm_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       ext_reset_n,
    input wire svrm_cmp_s  cmp_async,
    input wire logic       hoco_accurate,
    input wire svrm_opt_s  threshold_cfg,
    input wire logic       internal_reset,
    input wire logic       low_supply_irq,
    input wire logic       cpu_on_chip_osc,
    input wire logic [7:0] detector_control_reg,
    input wire logic [7:0] detector_level_reg,
    input wire logic [7:0] reset_cause_reg
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic m2;
    assign m2 = threshold_cfg.mode == MODE_INT_RST;

    // ----------------------------------------------------------------
    // interrupt and level register
    // ----------------------------------------------------------------
    a_irq_one_cycle: assert property (
        low_supply_irq |=> !low_supply_irq)
        else $error("interrupt longer than one cycle");
    a_irq_sets_level: assert property (
        m2 && low_supply_irq |-> ##[0:1] detector_level_reg == 8'h81)
        else $error("level bits not set after interrupt");
    a_mask_while_ren: assert property (
        m2 && detector_control_reg[7] && $past(detector_control_reg[7])
        |-> detector_control_reg[1])
        else $error("mask status low while rewrite enabled");
    a_ren_other_mode: assert property (
        !m2 |-> !detector_control_reg[7])
        else $error("rewrite enable set outside mode 2");

    // ----------------------------------------------------------------
    // reset cause and internal reset
    // ----------------------------------------------------------------
    a_cause_on_lvd: assert property (
        $rose(internal_reset) && ext_reset_n && $past(ext_reset_n)
        && $past(ext_reset_n, 2) |-> ##[0:2] reset_cause_reg[0])
        else $error("detector reset left cause flag clear");
    a_cause_pin_clr: assert property (
        !ext_reset_n ##1 !ext_reset_n |-> reset_cause_reg == 8'h00)
        else $error("pin reset kept cause flag");
    a_pin_resets: assert property (
        !ext_reset_n |-> ##[1:2] internal_reset)
        else $error("pin low without internal reset");
    a_osc_in_reset: assert property (
        internal_reset && $past(internal_reset) |-> cpu_on_chip_osc)
        else $error("cpu off on-chip clock during reset");
    a_hoco_before_run: assert property (
        $fell(internal_reset) |-> $past(hoco_accurate))
        else $error("reset released before oscillator accurate");

    // ----------------------------------------------------------------
    // voltage flag
    // ----------------------------------------------------------------
    a_flag_off_mode: assert property (
        threshold_cfg.mode == MODE_OFF
        && $past(threshold_cfg.mode) == MODE_OFF
        |-> !detector_control_reg[0])
        else $error("flag set with detector off");
    a_flag_follows: assert property (
        (threshold_cfg.mode == MODE_INT && cmp_async.below_low
        && !internal_reset) [*4] |-> detector_control_reg[0])
        else $error("flag misses supply below threshold");
endmodule

// ---- test/svrm_cpu_model.sv ----
// Purpose: cpu core side that takes reset and interrupt
// Assumes: software switches clock a while after each release
// Notes:   counts interrupt pulses for the bench
module svrm_cpu_model (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic internal_reset,
    input  wire logic low_supply_irq,
    output logic      clk_switch_req,
    output int        irq_count
);
    timeunit 1ns;
    timeprecision 1ps;
    int run_cycles;

    initial begin
        clk_switch_req = 1'b0;
        irq_count = 0;
        run_cycles = 0;
    end

    always @(posedge clk) begin
        clk_switch_req <= 1'b0;
        if (rst || internal_reset !== 1'b0) begin
            run_cycles <= 0;
        end else begin
            run_cycles <= run_cycles + 1;
            // crystal status assumed read before this point
            if (run_cycles == 8) begin
                clk_switch_req <= 1'b1;
            end
        end
        if (low_supply_irq === 1'b1) begin
            irq_count <= irq_count + 1;
        end
    end
endmodule

// ---- test/svrm_monitor_tb.sv ----
// Purpose: directed run of the supply monitor through all modes
// Assumes: shortened timing parameters, counts checked with slack
// Notes:   slack covers sync and load cycles of the processing
module svrm_monitor_tb
    import svrm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LP = 20, E1N = 60, E1F = 40, ENN = 50, ENF = 30;
    localparam int ST = 30;
    logic clk = 1'b0, rst = 1'b1, ext_reset_n = 1'b1, hoco_accurate = 1'b1;
    logic ctrl_wr = 1'b0, lvl_wr = 1'b0, cause_clear = 1'b0;
    logic [7:0] ctrl_wdata = 8'h00, lvl_wdata = 8'h00;
    svrm_opt_s opt_byte = '{level: 2'h0, mode: MODE_INT_RST};
    svrm_cmp_s cmp_async = '0;
    svrm_opt_s threshold_cfg;
    logic internal_reset, low_supply_irq, cpu_on_chip_osc, clk_switch_req;
    logic [7:0] detector_control_reg, detector_level_reg, reset_cause_reg;
    int fail_count = 0, check_count = 0, irq_count, n, base;

    always #5 clk = ~clk;

    svrm_monitor #(.LVD_PROC(LP), .EXT1_ON(E1N), .EXT1_OFF(E1F),
        .EXTN_ON(ENN), .EXTN_OFF(ENF), .SETTLE(ST)) dut_u (
        .clk(clk), .rst(rst), .ext_reset_n(ext_reset_n),
        .opt_byte(opt_byte), .cmp_async(cmp_async),
        .hoco_accurate(hoco_accurate), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(ctrl_wdata), .lvl_wr(lvl_wr), .lvl_wdata(lvl_wdata),
        .cause_clear(cause_clear), .clk_switch_req(clk_switch_req),
        .threshold_cfg(threshold_cfg), .internal_reset(internal_reset),
        .low_supply_irq(low_supply_irq), .cpu_on_chip_osc(cpu_on_chip_osc),
        .detector_control_reg(detector_control_reg),
        .detector_level_reg(detector_level_reg),
        .reset_cause_reg(reset_cause_reg));

    svrm_cpu_model cpu_u (.clk(clk), .rst(rst),
        .internal_reset(internal_reset), .low_supply_irq(low_supply_irq),
        .clk_switch_req(clk_switch_req), .irq_count(irq_count));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic check_byte(input string what, input logic [7:0] e,
                              input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic check_rng(input string what, input int lo,
                             input int hi, input int g);
        check_count++;
        if (g < lo || g > hi) begin
            fail_count++;
            $display("mismatch %s expected %0d..%0d seen %0d", what, lo,
                     hi, g);
        end
    endtask
    // bounded wait, under 3000 cycles: low_supply_irq or internal_reset at level v
    task automatic wait_for(input bit irq, input logic v, output int k);
        k = 0;
        while ((irq ? low_supply_irq : internal_reset) !== v && k < 3000) begin
            @(posedge clk);
            k++;
        end
        if (k >= 3000) begin
            check_rng("wait bound", 0, 2999, k);
            give_verdict();
        end
    endtask
    task automatic wr(input int which, input logic [7:0] d);
        @(posedge clk);
        ctrl_wr <= which == 0;
        lvl_wr <= which == 1;
        cause_clear <= which == 2;
        ctrl_wdata <= d;
        lvl_wdata <= d;
        tick(1);
        {ctrl_wr, lvl_wr, cause_clear} <= 3'b000;
        tick(1);
    endtask
    task automatic pin_reset();
        ext_reset_n <= 1'b0;
        tick(3);
        ext_reset_n <= 1'b1;
    endtask
    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask

    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial begin
        tick(10);
        rst <= 1'b0;
        wait_for(0, 1'b0, n);
        check_rng("first release", E1N, E1N + 10, n);
        check_byte("level", 8'h00, detector_level_reg);
        check_byte("control", 8'h00, detector_control_reg);
        tick(12);
        check_byte("osc", 8'h00, {7'h0, cpu_on_chip_osc});
        end_test("power_up_mode2");
        wr(0, 8'h80);
        check_byte("ren", 8'h01, {7'h0, detector_control_reg[7]});
        tick(1);
        check_byte("mask", 8'h01, {7'h0, detector_control_reg[1]});
        wr(1, 8'h01);
        check_byte("level wr", 8'h01, detector_level_reg);
        wr(0, 8'h00);
        tick(ST + 10);
        check_byte("mask off", 8'h00, {7'h0, detector_control_reg[1]});
        end_test("rewrite");
        cmp_async.below_high <= 1'b1;
        wait_for(1, 1'b1, n);
        tick(2);
        check_byte("level auto", 8'h81, detector_level_reg);
        check_byte("settling", 8'h01, {7'h0, detector_control_reg[1]});
        cmp_async.below_high <= 1'b0;
        end_test("irq_mode2");
        tick(ST + 10);
        check_byte("recover", 8'h00, {7'h0, internal_reset});
        hoco_accurate <= 1'b0;
        cmp_async <= '1;
        wait_for(0, 1'b1, n);
        check_rng("lvd reset", 0, 10, n);
        tick(3);
        check_byte("cause", 8'h01, reset_cause_reg);
        check_byte("level kept", 8'h81, detector_level_reg);
        cmp_async <= '0;
        tick(LP + 20);
        check_byte("hoco hold", 8'h01, {7'h0, internal_reset});
        hoco_accurate <= 1'b1;
        wait_for(0, 1'b0, n);
        check_byte("osc back", 8'h01, {7'h0, cpu_on_chip_osc});
        end_test("reset_mode2");
        opt_byte.mode <= MODE_RST;
        pin_reset();
        wait_for(0, 1'b0, n);
        check_rng("later release", ENN, ENN + 10, n);
        check_byte("level mode3", 8'h81, detector_level_reg);
        check_byte("cfg", {6'h00, MODE_RST}, {4'h0, threshold_cfg});
        check_byte("cause pin", 8'h00, reset_cause_reg);
        base = irq_count;
        cmp_async.below_low <= 1'b1;
        wait_for(0, 1'b1, n);
        check_rng("mode3 reset", 0, 10, n);
        tick(3);
        check_byte("cause mode3", 8'h01, reset_cause_reg);
        cmp_async.below_low <= 1'b0;
        wait_for(0, 1'b0, n);
        check_rng("lvd recovery", LP, LP + 10, n);
        check_rng("no irq mode3", base, base, irq_count);
        wr(2, 8'h00);
        check_byte("cause clear", 8'h00, reset_cause_reg);
        end_test("reset_mode3");
        opt_byte.mode <= MODE_INT;
        cmp_async.below_low <= 1'b1;
        pin_reset();
        tick(ENN + 30);
        check_byte("int hold", 8'h01, {7'h0, internal_reset});
        check_byte("flag below", 8'h01, {7'h0, detector_control_reg[0]});
        check_byte("level mode1", 8'h01, detector_level_reg);
        wr(0, 8'h80);
        check_byte("no ren", 8'h00, {7'h0, detector_control_reg[7]});
        cmp_async.below_low <= 1'b0;
        wait_for(0, 1'b0, n);
        check_byte("flag above", 8'h00, {7'h0, detector_control_reg[0]});
        base = irq_count;
        cmp_async.below_low <= 1'b1;
        tick(8);
        cmp_async.below_low <= 1'b0;
        tick(8);
        check_rng("both crossings", base + 2, base + 2, irq_count);
        check_byte("no reset mode1", 8'h00, {7'h0, internal_reset});
        end_test("irq_mode1");
        opt_byte.mode <= MODE_OFF;
        rst <= 1'b1;
        tick(10);
        rst <= 1'b0;
        wait_for(0, 1'b0, n);
        check_rng("first release off", E1F, E1F + 10, n);
        cmp_async.below_low <= 1'b1;
        tick(6);
        check_byte("flag off", 8'h00, {7'h0, detector_control_reg[0]});
        pin_reset();
        wait_for(0, 1'b0, n);
        check_rng("later release off", ENF, ENF + 10, n);
        end_test("detector_off");
        give_verdict();
    end
endmodule

bind svrm_monitor svrm_monitor_sva chk_u (
    .clk(clk), .rst(rst), .ext_reset_n(ext_reset_n),
    .cmp_async(cmp_async), .hoco_accurate(hoco_accurate),
    .threshold_cfg(threshold_cfg), .internal_reset(internal_reset),
    .low_supply_irq(low_supply_irq), .cpu_on_chip_osc(cpu_on_chip_osc),
    .detector_control_reg(detector_control_reg),
    .detector_level_reg(detector_level_reg),
    .reset_cause_reg(reset_cause_reg));
